// >>> rtl/dmr3_reg.sv
// mode register three storage and field decode
`timescale 1ns/1ps
module dmr3_reg
#(
  parameter int ADDR_W = dmr3_pkg::ADDR_W
)
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  dmr3_pkg::dmr3_mrs_t   mrs_cmd,
  output logic [6:0]            mr_select,
  output logic                  rcw_ignored,
  output logic                  mr3_write,
  output dmr3_pkg::dmr3_fields_t fields,
  output logic [2:0]            wr_crc_dm_lat,
  output logic                  wr_lat_rsvd,
  output logic                  refresh_rsvd,
  output logic                  fmt_rsvd,
  output logic                  fgr_otf,
  output logic [1:0]            fgr_rate_log2,
  output logic                  mpr_access,
  output logic                  array_access
);

  logic [ADDR_W-1:0] mr3_q;
  logic [ADDR_W-1:0] mr3_d;
  logic [2:0]        sel_index;
  logic              hit_mr3;

  dmr3_decode u_dec
  (
    .cmd        (mrs_cmd),
    .sel_onehot (mr_select),
    .rcw_hit    (rcw_ignored),
    .sel_index  (sel_index)
  );

  assign hit_mr3   = mr_select[dmr3_pkg::SEL_MR3];
  assign mr3_write = hit_mr3;
  assign mr3_d     = hit_mr3 ? mrs_cmd.addr : mr3_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      mr3_q <= dmr3_pkg::MR3_RESET;
    else
      mr3_q <= mr3_d;
  end

  assign fields.rd_format        = dmr3_pkg::dmr3_fmt_t'(mr3_q[dmr3_pkg::FMT_LSB +: 2]);
  assign fields.wr_lat_code      = mr3_q[dmr3_pkg::WLAT_LSB +: 2];
  assign fields.refresh_mode     = dmr3_pkg::dmr3_fgr_t'(mr3_q[dmr3_pkg::FGR_LSB +: 3]);
  assign fields.temp_readout_en  = mr3_q[dmr3_pkg::TS_BIT];
  assign fields.per_dev_addr_en  = mr3_q[dmr3_pkg::PDA_BIT];
  assign fields.geardown_quarter = mr3_q[dmr3_pkg::GD_BIT];
  assign fields.mpr_dataflow     = mr3_q[dmr3_pkg::MPRE_BIT];
  assign fields.mpr_page         = mr3_q[dmr3_pkg::PAGE_LSB +: 2];

  // latency: 4, 5 or 6 clocks; reserved code reads as 0
  assign wr_lat_rsvd   = (fields.wr_lat_code == 2'h3);
  assign wr_crc_dm_lat = wr_lat_rsvd ? 3'h0
                       : 3'(dmr3_pkg::WLAT_BASE + {1'b0, fields.wr_lat_code});

  assign fmt_rsvd = (fields.rd_format == dmr3_pkg::DMR3_FMT_RSVD);

  always_comb
  begin
    refresh_rsvd  = 1'b0;
    fgr_otf       = 1'b0;
    fgr_rate_log2 = 2'h0;
    unique case (fields.refresh_mode)
      dmr3_pkg::DMR3_FGR_1X:     fgr_rate_log2 = 2'h0;
      dmr3_pkg::DMR3_FGR_2X:     fgr_rate_log2 = 2'h1;
      dmr3_pkg::DMR3_FGR_4X:     fgr_rate_log2 = 2'h2;
      dmr3_pkg::DMR3_FGR_OTF_2X:
      begin
        fgr_otf       = 1'b1;
        fgr_rate_log2 = 2'h1;
      end
      dmr3_pkg::DMR3_FGR_OTF_4X:
      begin
        fgr_otf       = 1'b1;
        fgr_rate_log2 = 2'h2;
      end
      default:                   refresh_rsvd = 1'b1;
    endcase
  end

  assign mpr_access   = fields.mpr_dataflow;
  assign array_access = !fields.mpr_dataflow;

  // checks
  property p_write_loads;
    @(posedge core_clk) disable iff (rst)
    hit_mr3 |=> (mr3_q == $past(mrs_cmd.addr));
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("mr3 not loaded");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
    !hit_mr3 |=> $stable(mr3_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mr3 changed without write");

  property p_rcw_ignore;
    @(posedge core_clk) disable iff (rst)
    (mrs_cmd.valid && {mrs_cmd.bg0, mrs_cmd.ba} == 3'h7) |-> (mr_select == 7'h00)
      ##1 $stable(mr3_q);
  endproperty
  a_rcw_ignore: assert property (p_rcw_ignore) else $error("rcw code not ignored");

  property p_select;
    @(posedge core_clk) disable iff (rst)
    (mrs_cmd.valid && {mrs_cmd.bg0, mrs_cmd.ba} != 3'h7)
      |-> $onehot(mr_select) && mr_select[{mrs_cmd.bg0, mrs_cmd.ba}];
  endproperty
  a_select: assert property (p_select) else $error("wrong register selected");

  property p_lat;
    @(posedge core_clk) disable iff (rst)
    (hit_mr3 && mrs_cmd.addr[10:9] != 2'h3)
      |=> (wr_crc_dm_lat == 3'(4 + $past(mrs_cmd.addr[10:9])));
  endproperty
  a_lat: assert property (p_lat) else $error("write latency wrong");

  property p_fgr;
    @(posedge core_clk) disable iff (rst)
    (hit_mr3 && mrs_cmd.addr[8:6] == 3'h6) |=> (fgr_otf && fgr_rate_log2 == 2'h2);
  endproperty
  a_fgr: assert property (p_fgr) else $error("refresh mode wrong");

  property p_fgr_rsvd;
    @(posedge core_clk) disable iff (rst)
    (hit_mr3 && mrs_cmd.addr[8:6] inside {3'h3, 3'h4, 3'h7}) |=> refresh_rsvd;
  endproperty
  a_fgr_rsvd: assert property (p_fgr_rsvd) else $error("reserved refresh missed");

  property p_flags;
    @(posedge core_clk) disable iff (rst)
    hit_mr3 |=> (fields.temp_readout_en == $past(mrs_cmd.addr[5]))
      && (fields.per_dev_addr_en == $past(mrs_cmd.addr[4]))
      && (fields.geardown_quarter == $past(mrs_cmd.addr[3]));
  endproperty
  a_flags: assert property (p_flags) else $error("flag bits wrong");

  property p_mpr;
    @(posedge core_clk) disable iff (rst)
    hit_mr3 |=> (mpr_access == $past(mrs_cmd.addr[2])) && (array_access != mpr_access)
      && (fields.mpr_page == $past(mrs_cmd.addr[1:0]))
      && (fmt_rsvd == ($past(mrs_cmd.addr[12:11]) == 2'h3));
  endproperty
  a_mpr: assert property (p_mpr) else $error("mpr fields wrong");

  c_write: cover property (@(posedge core_clk) disable iff (rst) hit_mr3);
  c_rcw:   cover property (@(posedge core_clk) disable iff (rst) rcw_ignored);
  c_mpr:   cover property (@(posedge core_clk) disable iff (rst) hit_mr3 ##1 mpr_access);
  c_otf:   cover property (@(posedge core_clk) disable iff (rst) fgr_otf);

endmodule

// >>> rtl/dmr3_pkg.sv
// package: constants, types and field layout of mode register three
package dmr3_pkg;

  localparam int ADDR_W = 18;
  localparam int SEL_W  = 3;

  localparam logic [2:0] SEL_MR3 = 3'h3;
  localparam logic [2:0] SEL_RCW = 3'h7;

  localparam int FMT_LSB  = 11;
  localparam int WLAT_LSB = 9;
  localparam int FGR_LSB  = 6;
  localparam int TS_BIT   = 5;
  localparam int PDA_BIT  = 4;
  localparam int GD_BIT   = 3;
  localparam int MPRE_BIT = 2;
  localparam int PAGE_LSB = 0;

  localparam logic [17:0] MR3_RESET = 18'h00000;

  localparam logic [2:0] WLAT_BASE = 3'h4;

  typedef enum logic [1:0] {
    DMR3_FMT_SERIAL,
    DMR3_FMT_PARALLEL,
    DMR3_FMT_STAGGER,
    DMR3_FMT_RSVD
  } dmr3_fmt_t;

  typedef enum logic [2:0] {
    DMR3_FGR_1X     = 3'h0,
    DMR3_FGR_2X     = 3'h1,
    DMR3_FGR_4X     = 3'h2,
    DMR3_FGR_RSVD3  = 3'h3,
    DMR3_FGR_RSVD4  = 3'h4,
    DMR3_FGR_OTF_2X = 3'h5,
    DMR3_FGR_OTF_4X = 3'h6,
    DMR3_FGR_RSVD7  = 3'h7
  } dmr3_fgr_t;

  typedef struct packed {
    dmr3_fmt_t  rd_format;
    logic [1:0] wr_lat_code;
    dmr3_fgr_t  refresh_mode;
    logic       temp_readout_en;
    logic       per_dev_addr_en;
    logic       geardown_quarter;
    logic       mpr_dataflow;
    logic [1:0] mpr_page;
  } dmr3_fields_t;

  typedef struct packed {
    logic        valid;
    logic        bg1;
    logic        bg0;
    logic [1:0]  ba;
    logic [17:0] addr;
  } dmr3_mrs_t;

endpackage

// >>> rtl/dmr3_decode.sv
// select-code decoder for mode register set commands
`timescale 1ns/1ps
module dmr3_decode
(
  input  dmr3_pkg::dmr3_mrs_t cmd,
  output logic [6:0]     sel_onehot,
  output logic           rcw_hit,
  output logic [2:0]     sel_index
);

  assign sel_index = {cmd.bg0, cmd.ba};
  assign rcw_hit   = cmd.valid && (sel_index == dmr3_pkg::SEL_RCW);

  always_comb
  begin
    sel_onehot = 7'h00;
    if (cmd.valid && !rcw_hit)
    begin
      sel_onehot[sel_index] = 1'b1;
    end
  end

endmodule

// >>> tb/dmr3_ctrl_model.sv
// controller model issuing mode register set commands
`timescale 1ns/1ps
module dmr3_ctrl_model
(
  input  wire logic          core_clk,
  output dmr3_pkg::dmr3_mrs_t mrs_cmd
);
  initial mrs_cmd = '0;

  // legal field codes only
  function automatic logic [12:0] legal(input logic [31:0] r);
    logic [2:0] fgr [5];
    fgr = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    return {2'(r[12:11] % 3), 2'(r[10:9] % 3), fgr[r[8:6] % 5], r[5:0]};
  endfunction

  task automatic drive(input logic [2:0] sel, input logic [12:0] f);
    @(posedge core_clk);
    #1;
    mrs_cmd.valid = 1'b1;
    mrs_cmd.bg1   = 1'b0;
    {mrs_cmd.bg0, mrs_cmd.ba} = sel;
    mrs_cmd.addr  = {5'h00, f};
  endtask

  task automatic idle();
    @(posedge core_clk);
    #1;
    mrs_cmd.valid = 1'b0;
    mrs_cmd.addr  = ~mrs_cmd.addr;
  endtask
endmodule

// >>> tb/ddr4_mode_register_three_decode_tb_top.sv
// self-checking bench for mode register three
`timescale 1ns/1ps
module ddr4_mode_register_three_decode_tb_top;
  logic                   core_clk;
  logic                   rst;
  dmr3_pkg::dmr3_mrs_t    mrs_cmd;
  logic [6:0]             mr_select;
  logic                   rcw_ignored;
  logic                   mr3_write;
  dmr3_pkg::dmr3_fields_t fields;
  logic [2:0]             wr_crc_dm_lat;
  logic                   fgr_otf;
  logic [1:0]             fgr_rate_log2;
  logic                   wr_lat_rsvd;
  logic                   refresh_rsvd;
  logic                   fmt_rsvd;
  logic                   mpr_access;
  logic                   array_access;
  logic [12:0]            e;
  int                     n_fail;
  int                     n_tests;

  dmr3_ctrl_model u_dmr3_ctrl_model (.core_clk(core_clk), .mrs_cmd(mrs_cmd));

  dmr3_reg u_dmr3_reg (
    .core_clk(core_clk), .rst(rst), .mrs_cmd(mrs_cmd), .mr_select(mr_select),
    .rcw_ignored(rcw_ignored), .mr3_write(mr3_write), .fields(fields),
    .wr_crc_dm_lat(wr_crc_dm_lat), .wr_lat_rsvd(wr_lat_rsvd),
    .refresh_rsvd(refresh_rsvd), .fmt_rsvd(fmt_rsvd),
    .fgr_otf(fgr_otf), .fgr_rate_log2(fgr_rate_log2), .mpr_access(mpr_access),
    .array_access(array_access)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [6:0] exp_sel(input logic [2:0] s);
    return (s == 3'h7) ? 7'h00 : 7'h01 << s;
  endfunction

  // refresh rate as log2 of the multiplier for a refresh code
  function automatic logic [1:0] exp_rate(input logic [2:0] c);
    case (c)
      3'h1, 3'h5: return 2'h1;
      3'h2, 3'h6: return 2'h2;
      default:    return 2'h0;
    endcase
  endfunction

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic look();
    chk(18'(fields), 18'(e), "fields");
    chk(18'(wr_crc_dm_lat), 18'(3'h4 + e[10:9]), "wlat");
    chk(18'({mpr_access, array_access}), 18'({e[2], ~e[2]}), "path");
    chk(18'(fgr_otf), 18'(e[8]), "otf");
    chk(18'(fgr_rate_log2), 18'(exp_rate(e[8:6])), "rate");
    chk(18'({wr_lat_rsvd, refresh_rsvd, fmt_rsvd}), 18'h00000, "rsvd");
  endtask

  task automatic step(input logic [2:0] s, input logic [12:0] f);
    u_dmr3_ctrl_model.drive(s, f);
    #1;
    chk(18'(mr_select), 18'(exp_sel(s)), "select");
    chk(18'({rcw_ignored, mr3_write}), 18'({s == 3'h7, s == 3'h3}), "strobes");
    look();
    if (s == 3'h3)
      e = f;
  endtask

  task automatic stop_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_fail++;
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    e = 13'h0000;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(24));
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      step(3'(i), u_dmr3_ctrl_model.legal($urandom));
    $display("select decode done");
    for (int i = 0; i < 5; i++)
      step(3'h3, u_dmr3_ctrl_model.legal({19'h0, 3'(i), 2'(i), 2'(i), 6'($urandom)}));
    $display("field codes done");
    for (int i = 0; i < 60; i++)
      step(3'($urandom), u_dmr3_ctrl_model.legal($urandom));
    u_dmr3_ctrl_model.idle();
    #1;
    look();
    repeat (3) @(posedge core_clk);
    #1;
    look();
    $display("random writes done");
    stop_test();
  end
endmodule
